// [logic/spsc_pkg.sv]
`default_nettype none
package spsc_pkg;
	localparam int unsigned SPSC_CLK_NS = 25;
	localparam int unsigned SPSC_RAM_LEAD_CYC = 10;
	localparam int unsigned SPSC_EXIT_LEAD_NS = 100;
	localparam int unsigned SPSC_EXIT_LEAD_CYC = (SPSC_EXIT_LEAD_NS + SPSC_CLK_NS - 1) / SPSC_CLK_NS;
	localparam int unsigned SPSC_PW = 8;
	localparam logic [31:0] SPSC_OFF_CTRL = 32'h0000_0000;
	localparam logic [31:0] SPSC_OFF_DIR = 32'h0000_0004;
	localparam logic [31:0] SPSC_OFF_LATCH = 32'h0000_0008;
	localparam logic [31:0] SPSC_OFF_PERI = 32'h0000_000c;
	localparam logic [31:0] SPSC_OFF_STAT = 32'h0000_0010;
	localparam logic [31:0] SPSC_OFF_ADDR = 32'h0000_0014;
	localparam int unsigned SPSC_B_RAM_EN = 0;
	localparam int unsigned SPSC_B_SWSTBY = 1;
	localparam int unsigned SPSC_B_SLEEP = 2;
	localparam int unsigned SPSC_B_MODE = 4;
	localparam logic [1:0] SPSC_MODE_SINGLE = 2'h3;
	localparam logic [1:0] SPSC_MODE_EXPSEL = 2'h2;
	localparam logic [7:0] SPSC_CLK_PIN = 8'h06;
	typedef enum logic [2:0] {SPSC_RUN, SPSC_INIT, SPSC_HWSTBY, SPSC_EXIT} spsc_state_e;
	typedef struct packed {
		logic [SPSC_PW-1:0] out;
		logic [SPSC_PW-1:0] oe_n;
		logic [SPSC_PW-1:0] pull;
	} spsc_pins_s;
endpackage : spsc_pkg
`default_nettype wire

// [logic/spsc_top.sv]
// Added by the designer: the address map and the AHB-Lite register port.
`default_nettype none
// Behaviour
// RULE_01 - With RAM kept, board asserts chip init 10 clocks before deep sleep pin.
// RULE_02 - Board keeps chip init asserted until deep sleep pin is low.
// RULE_03 - Without RAM retention, chip init need not lead the deep sleep pin.
// RULE_04 - Board asserts chip init about 100 ns before releasing deep sleep.
// RULE_05 - Held input pins float; pull-up only when direction 0 and latch 1.
// RULE_06 - Held output pins keep driving their last output level.
// RULE_07 - Peripheral pins revert to general ports when peripherals reset on state change.
// RULE_08 - General port direction follows its direction bit, unless a peripheral owns it.
// RULE_09 - Single-chip software standby: clock pin high if direction 1, else floating.
// RULE_10 - Single-chip sleep: clock pin carries system clock if direction 1, else floats.
// RULE_11 - Single-chip normal: clock pin outputs clock if direction 1, else input.
// RULE_12 - Expanded select mode standby: address pins low if direction 1, else held.
// RULE_13 - During sleep, address pins keep driving the last accessed address.
// RULE_14 - Hardware standby floats every port pin regardless of mode or direction.
module spsc_top
	import spsc_pkg::*;
(
	input  wire logic               CLK_IN,
	input  wire logic               SYS_RST_IN,
	input  wire logic               CHIP_INIT_N_IN,
	input  wire logic               DEEP_SLEEP_PIN_N_IN,
	input  wire logic [SPSC_PW-1:0] PERI_OUT_IN,
	input  wire logic [SPSC_PW-1:0] PIN_IN,
	input  wire logic [31:0]        HADDR,
	input  wire logic [1:0]         HTRANS,
	input  wire logic               HWRITE,
	input  wire logic [2:0]         HSIZE,
	input  wire logic [31:0]        HWDATA,
	input  wire logic               HSEL,
	input  wire logic               HREADY,
	output logic [31:0]             HRDATA,
	output logic                    HREADYOUT,
	output logic                    HRESP,
	output logic [SPSC_PW-1:0]      PIN_OUT,
	output logic [SPSC_PW-1:0]      PIN_OE_N_OUT,
	output logic [SPSC_PW-1:0]      PIN_PULLUP_OUT,
	output logic [SPSC_PW-1:0]      ADDR_PIN_OUT,
	output logic                    CLK_PIN_OUT,
	output logic                    CLK_PIN_OE_N_OUT,
	output logic                    HW_STANDBY_OUT,
	output logic                    RAM_KEEP_OK_OUT
);
	// ==========================================
	// Bus slave
	logic [31:0]        ctrl_reg;
	logic [SPSC_PW-1:0] dir_reg;
	logic [SPSC_PW-1:0] latch_reg;
	logic [SPSC_PW-1:0] peri_reg;
	logic [SPSC_PW-1:0] addr_reg;
	logic [31:0]        a_addr_reg;
	logic               a_wr_reg;
	logic               a_rd_reg;
	logic [31:0]        rd_next;
	spsc_state_e        state_reg;
	logic [3:0]         lead_reg;
	logic               ram_ok_reg;
	logic               init_q_reg;
	wire                take = HSEL && HREADY && HTRANS[1];
	wire                wr_en = a_wr_reg;
	wire [1:0]          mode = ctrl_reg[SPSC_B_MODE +: 2];
	wire                sw_standby = ctrl_reg[SPSC_B_SWSTBY];
	wire                sleep = ctrl_reg[SPSC_B_SLEEP] && !sw_standby;
	wire                hw_standby = (state_reg == SPSC_HWSTBY);
	wire                ram_en = ctrl_reg[SPSC_B_RAM_EN];
	wire                in_init = (state_reg == SPSC_INIT) || (state_reg == SPSC_EXIT);
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			a_wr_reg   <= 1'b0;
			a_rd_reg   <= 1'b0;
			a_addr_reg <= 32'h0000_0000;
		end else begin
			a_wr_reg   <= take && HWRITE;
			a_rd_reg   <= take && !HWRITE;
			a_addr_reg <= HADDR;
		end
	end
	always_comb begin
		rd_next = 32'h0000_0000;
		case (a_addr_reg)
			SPSC_OFF_CTRL:  rd_next = ctrl_reg;
			SPSC_OFF_DIR:   rd_next = {24'h000000, dir_reg};
			SPSC_OFF_LATCH: rd_next = {24'h000000, latch_reg};
			SPSC_OFF_PERI:  rd_next = {24'h000000, peri_reg};
			SPSC_OFF_STAT:  rd_next = {29'h0, ram_ok_reg, hw_standby, in_init};
			SPSC_OFF_ADDR:  rd_next = {24'h000000, addr_reg};
			default:        rd_next = 32'h0000_0000;
		endcase
	end
	assign HRDATA = a_rd_reg ? rd_next : 32'h0000_0000;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	// ==========================================
	// Registers, cleared on chip init except the RAM enable bit, so peripherals drop their pins
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN || in_init) begin
			dir_reg   <= 8'h00;
			latch_reg <= 8'h00;
			peri_reg  <= 8'h00;
			addr_reg  <= 8'h00;
			ctrl_reg  <= {ctrl_reg[31:1] & 31'h0, (SYS_RST_IN ? 1'b0 : ram_en)};
		end else begin
			if (sw_standby) begin
				peri_reg <= 8'h00; // RULE_07
			end
			if (wr_en && a_addr_reg == SPSC_OFF_CTRL) ctrl_reg <= HWDATA;
			if (wr_en && a_addr_reg == SPSC_OFF_DIR) dir_reg <= HWDATA[SPSC_PW-1:0];
			if (wr_en && a_addr_reg == SPSC_OFF_LATCH) latch_reg <= HWDATA[SPSC_PW-1:0];
			if (wr_en && a_addr_reg == SPSC_OFF_PERI && !sw_standby) peri_reg <= HWDATA[SPSC_PW-1:0];
			if (wr_en && a_addr_reg == SPSC_OFF_ADDR && !sleep) addr_reg <= HWDATA[SPSC_PW-1:0]; // RULE_13
		end
	end
	// ==========================================
	// Hardware standby sequencing
	// Chip init is watched for its lead before standby; a short lead loses RAM retention.
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			state_reg  <= SPSC_RUN;
			lead_reg   <= 4'h0;
			ram_ok_reg <= 1'b0;
			init_q_reg <= 1'b1;
		end else begin
			init_q_reg <= CHIP_INIT_N_IN;
			case (state_reg)
				SPSC_RUN: begin
					lead_reg <= 4'h0;
					if (!DEEP_SLEEP_PIN_N_IN) begin
						state_reg  <= SPSC_HWSTBY;
						ram_ok_reg <= 1'b0; // RULE_03
					end else if (!CHIP_INIT_N_IN) begin
						state_reg <= SPSC_INIT;
					end
				end
				SPSC_INIT: begin
					if (lead_reg != 4'hf) lead_reg <= lead_reg + 4'h1;
					if (!DEEP_SLEEP_PIN_N_IN) begin
						state_reg  <= SPSC_HWSTBY;
						ram_ok_reg <= ram_en
							&& (32'(lead_reg) >= SPSC_RAM_LEAD_CYC - 1); // RULE_01
					end else if (CHIP_INIT_N_IN) begin
						state_reg <= SPSC_RUN;
					end
				end
				SPSC_HWSTBY: begin
					// On standby release, go to the exit state if init is low, else straight back to run. RULE_04
					if (DEEP_SLEEP_PIN_N_IN) state_reg <= CHIP_INIT_N_IN ? SPSC_RUN : SPSC_EXIT;
				end
				SPSC_EXIT: begin
					if (CHIP_INIT_N_IN) state_reg <= SPSC_RUN; // RULE_02
				end
				default: state_reg <= SPSC_RUN;
			endcase
		end
	end
	assign HW_STANDBY_OUT = hw_standby;
	assign RAM_KEEP_OK_OUT = ram_ok_reg;
	// ==========================================
	// Pin states
	spsc_pins_s pins;
	genvar g;
	generate
		for (g = 0; g < SPSC_PW; g++) begin : g_pin
			wire own = peri_reg[g] && !sw_standby && !sleep; // RULE_08
			wire drv = own || dir_reg[g]; // RULE_08
			assign pins.out[g] = own ? PERI_OUT_IN[g] : latch_reg[g]; // RULE_06
			assign pins.oe_n[g] = hw_standby || in_init || !drv; // RULE_14
			assign pins.pull[g] = !hw_standby && !in_init && !drv && latch_reg[g]; // RULE_05
		end
	endgenerate
	assign PIN_OUT = pins.out;
	assign PIN_OE_N_OUT = pins.oe_n;
	assign PIN_PULLUP_OUT = pins.pull;
	wire addr_standby_low = (mode == SPSC_MODE_EXPSEL) && sw_standby; // RULE_12
	assign ADDR_PIN_OUT = addr_standby_low ? (addr_reg & ~dir_reg) : addr_reg; // RULE_12
	wire ck_dir = dir_reg[SPSC_CLK_PIN[2:0]];
	wire single = (mode == SPSC_MODE_SINGLE);
	// Clock pin: forced high in single-chip software standby, else the system clock. RULE_09 RULE_10 RULE_11
	assign CLK_PIN_OUT = (single && sw_standby) ? 1'b1 : CLK_IN;
	assign CLK_PIN_OE_N_OUT = hw_standby || (single ? !ck_dir : in_init);
	// ==========================================
	// Checks
	hw_float_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_14
		hw_standby |-> (PIN_OE_N_OUT == 8'hff) && CLK_PIN_OE_N_OUT)
		else $error("pins driven in hardware standby");
	pull_gate_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_05
		(PIN_PULLUP_OUT & ~(PIN_OE_N_OUT & latch_reg)) == 8'h00)
		else $error("pull-up on wrong pin");
	standby_ckhi_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_09
		single && sw_standby && !hw_standby && ck_dir |-> CLK_PIN_OUT && !CLK_PIN_OE_N_OUT)
		else $error("clock pin not high in standby");
	ck_float_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_11
		single && !ck_dir |-> CLK_PIN_OE_N_OUT)
		else $error("clock pin driven with direction 0");
	addr_low_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_12
		addr_standby_low |-> (ADDR_PIN_OUT & dir_reg) == 8'h00)
		else $error("address pin not low");
	addr_hold_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_13
		sleep && $past(sleep) |-> $stable(addr_reg))
		else $error("address moved in sleep");
	out_hold_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_06
		!pins.oe_n[0] && !peri_reg[0] |-> PIN_OUT[0] == latch_reg[0])
		else $error("output level lost");
	ram_lead_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_01
		$rose(ram_ok_reg) |-> $past(lead_reg) >= 4'h9)
		else $error("RAM kept with short lead");
	// ==========================================
	// Clock pin and port direction checks
	// These checks pin down the sleep, normal, software standby and expanded
	// modes of the clock pin separately, because a single combined expression would hide which mode went wrong.
	sleep_ck_drive_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_10
		single && sleep && !hw_standby && ck_dir
		|-> !CLK_PIN_OE_N_OUT)
		else $error("clock pin not driven in sleep");
	sleep_ck_float_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_10
		single && sleep && !ck_dir
		|-> CLK_PIN_OE_N_OUT)
		else $error("clock pin driven in sleep with direction 0");
	run_ck_drive_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_11
		single && !sw_standby && !sleep && !hw_standby && ck_dir
		|-> !CLK_PIN_OE_N_OUT)
		else $error("clock pin not driven in normal operation");
	sw_ck_float_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_09
		single && sw_standby && !ck_dir
		|-> CLK_PIN_OE_N_OUT)
		else $error("clock pin driven in standby with direction 0");
	sw_ck_level_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_09
		single && sw_standby
		|-> CLK_PIN_OUT)
		else $error("clock pin level not high in standby");
	exp_ck_drive_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_11
		!single && !hw_standby && !in_init
		|-> !CLK_PIN_OE_N_OUT)
		else $error("clock pin not driven in expanded mode");
	gp_dir_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_08
		!hw_standby && !in_init
		|-> (((~PIN_OE_N_OUT) ^ dir_reg) & ~peri_reg) == 8'h00)
		else $error("port direction differs from direction bit");
	peri_drive_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_08
		!hw_standby && !in_init && !sw_standby && !sleep
		|-> (PIN_OE_N_OUT & peri_reg) == 8'h00)
		else $error("peripheral pin not driven");
	peri_level_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_08
		!sw_standby && !sleep
		|-> ((PIN_OUT ^ PERI_OUT_IN) & peri_reg) == 8'h00)
		else $error("peripheral level not on pin");
	// ==========================================
	// State change and hold checks
	// Peripheral ownership must be gone one edge after standby is seen, so a
	// pin never keeps a peripheral level that no running module produces.
	peri_drop_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_07
		sw_standby
		|=> (peri_reg == 8'h00))
		else $error("peripheral kept its pins in standby");
	init_float_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_07
		in_init
		|-> (PIN_OE_N_OUT == 8'hff) && (PIN_PULLUP_OUT == 8'h00))
		else $error("pin driven during chip init");
	init_clear_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_07
		in_init
		|=> (peri_reg == 8'h00) && (dir_reg == 8'h00))
		else $error("port bits survived chip init");
	pull_exact_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_05
		!hw_standby && !in_init
		|-> PIN_PULLUP_OUT == (PIN_OE_N_OUT & latch_reg))
		else $error("pull-up differs from input and latch");
	held_level_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_06
		!in_init
		|-> ((PIN_OUT ^ latch_reg) & ~PIN_OE_N_OUT & ~peri_reg) == 8'h00)
		else $error("output pin lost its latch level");
	addr_keep_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_12
		addr_standby_low
		|-> ((ADDR_PIN_OUT ^ addr_reg) & ~dir_reg) == 8'h00)
		else $error("input address pin not held");
	addr_pass_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_13
		!addr_standby_low
		|-> ADDR_PIN_OUT == addr_reg)
		else $error("address pins differ from last address");
	addr_frozen_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_13
		sleep && wr_en && (a_addr_reg == SPSC_OFF_ADDR) && !in_init
		|=> $stable(addr_reg))
		else $error("address written during sleep");
	// ==========================================
	// Hardware standby sequencing checks
	hw_pull_off_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_14
		hw_standby
		|-> PIN_PULLUP_OUT == 8'h00)
		else $error("pull-up on in hardware standby");
	hw_enter_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_14
		((state_reg == SPSC_RUN) || (state_reg == SPSC_INIT)) && !DEEP_SLEEP_PIN_N_IN
		|=> hw_standby)
		else $error("hardware standby not entered");
	hw_stay_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_14
		hw_standby && !DEEP_SLEEP_PIN_N_IN
		|=> hw_standby)
		else $error("hardware standby left early");
	ram_gate_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_01
		$rose(ram_ok_reg)
		|-> $past(ram_en))
		else $error("RAM kept with RAM enable clear");
	ram_short_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE_03
		hw_standby && !$past(hw_standby) && ($past(state_reg) == SPSC_RUN)
		|-> !ram_ok_reg)
		else $error("RAM kept without chip init lead");
endmodule : spsc_top
`default_nettype wire

// [tb/spsc_board.sv]
`default_nettype none
// =====================================
// Board-side sequencing of chip init and deep sleep.
module spsc_board_model
	import spsc_pkg::*;
(
	input  wire logic clk_in,
	output logic      chip_init_n_out,
	output logic      deep_sleep_n_out
);
	initial begin
		chip_init_n_out = 1'b1;
		deep_sleep_n_out = 1'b1;
	end
	// A lead of zero skips chip init, allowed when RAM need not survive.
	task automatic enter(input int lead);
		if (lead > 0) begin
			chip_init_n_out <= 1'b0;
			repeat (lead) @(posedge clk_in);
		end
		deep_sleep_n_out <= 1'b0;
		@(posedge clk_in);
		chip_init_n_out <= 1'b1;
	endtask : enter
	task automatic leave();
		chip_init_n_out <= 1'b0;
		repeat (SPSC_EXIT_LEAD_CYC) @(posedge clk_in);
		deep_sleep_n_out <= 1'b1;
		@(posedge clk_in);
		chip_init_n_out <= 1'b1;
	endtask : leave
endmodule : spsc_board_model
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module testbench
	import spsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0, rst = 1'b1, hwrite = 1'b0;
	logic [1:0]        htrans = 2'h0;
	logic [31:0]       haddr = 32'h0, hwdata = 32'h0, rd;
	wire logic [31:0]  hrdata;
	wire logic         hready, init_n, slp_n, clk_pin, clk_oe_n, hw_standby, ram_ok;
	wire logic [7:0]   pin, oe_n, pull, apin;
	int                err_total = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	spsc_board_model board (.clk_in(clk), .chip_init_n_out(init_n), .deep_sleep_n_out(slp_n));
	spsc_top dut (.CLK_IN(clk), .SYS_RST_IN(rst), .CHIP_INIT_N_IN(init_n),
		.DEEP_SLEEP_PIN_N_IN(slp_n), .PERI_OUT_IN(8'h5a), .PIN_IN(8'h00), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HSEL(1'b1),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .PIN_OUT(pin),
		.PIN_OE_N_OUT(oe_n), .PIN_PULLUP_OUT(pull), .ADDR_PIN_OUT(apin),
		.CLK_PIN_OUT(clk_pin), .CLK_PIN_OE_N_OUT(clk_oe_n), .HW_STANDBY_OUT(hw_standby),
		.RAM_KEEP_OK_OUT(ram_ok));
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	// =====================================
	// Bus master; a wait that runs out ends the run.
	task automatic wait_rdy();
		int i;
		i = 0;
		do begin
			@(posedge clk);
			if (++i > 50) begin
				err_total++;
				final_report();
			end
		end while (hready !== 1'b1);
	endtask : wait_rdy
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask : xfer
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	// =====================================
	// Scenarios.
	task automatic t_normal();
		xfer(1, SPSC_OFF_DIR, 32'hff);
		xfer(1, SPSC_OFF_LATCH, 32'h00);
		xfer(1, SPSC_OFF_PERI, 32'h0f);
		xfer(0, 32'h20, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		settle();
		`CHK("peri pins", 8'h0a, pin)
		`CHK("drive", 8'h00, oe_n)
		$display("normal done");
	endtask : t_normal
	task automatic t_hold();
		xfer(1, SPSC_OFF_PERI, 32'h0f);
		xfer(1, SPSC_OFF_DIR, 32'h4f);
		xfer(1, SPSC_OFF_LATCH, 32'hf5);
		xfer(1, SPSC_OFF_CTRL, 32'h02);
		xfer(0, SPSC_OFF_PERI, 32'h0);
		`CHK("peri drop", 32'h0, rd)
		xfer(0, SPSC_OFF_LATCH, 32'h0);
		`CHK("latch rd", 32'hf5, rd)
		settle();
		`CHK("held oe", 8'hb0, oe_n)
		`CHK("pullup", 8'hb0, pull)
		`CHK("held out", 8'h45, pin & 8'h4f)
		$display("hold done");
	endtask : t_hold
	task automatic t_clkpin();
		xfer(1, SPSC_OFF_CTRL, 32'h30);
		settle();
		`CHK("clk oe run", 1'b0, clk_oe_n)
		xfer(1, SPSC_OFF_CTRL, 32'h32);
		settle();
		`CHK("clk sw", 2'b10, {clk_pin, clk_oe_n})
		xfer(1, SPSC_OFF_CTRL, 32'h34);
		settle();
		`CHK("clk oe sleep", 1'b0, clk_oe_n)
		xfer(1, SPSC_OFF_DIR, 32'h0f);
		settle();
		`CHK("clk float", 1'b1, clk_oe_n)
		$display("clock pin done");
	endtask : t_clkpin
	task automatic t_addr();
		xfer(1, SPSC_OFF_CTRL, 32'h20);
		xfer(1, SPSC_OFF_ADDR, 32'h3c);
		xfer(1, SPSC_OFF_CTRL, 32'h24);
		xfer(1, SPSC_OFF_ADDR, 32'h11);
		settle();
		`CHK("addr sleep", 8'h3c, apin)
		xfer(1, SPSC_OFF_CTRL, 32'h22);
		settle();
		`CHK("addr sw", 8'h30, apin)
		$display("address done");
	endtask : t_addr
	task automatic t_hwstby(input int lead, input logic ok);
		xfer(1, SPSC_OFF_CTRL, 32'h31);
		@(posedge clk);
		board.enter(lead);
		settle();
		`CHK("hw standby", 1'b1, hw_standby)
		`CHK("float all", 9'h1ff, {clk_oe_n, oe_n})
		`CHK("ram ok", ok, ram_ok)
		@(posedge clk);
		board.leave();
		settle();
		`CHK("hw exit", 1'b0, hw_standby)
		$display("hardware standby done");
	endtask : t_hwstby
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_normal();
		t_hold();
		t_clkpin();
		t_addr();
		t_hwstby(SPSC_RAM_LEAD_CYC, 1'b1);
		t_hwstby(0, 1'b0);
		final_report();
	end
endmodule : testbench
`undef CHK
`default_nettype wire
